// ===== bench/tcm_channel_config_checker.sv
`timescale 1ns/1ps

// watches bus answers and the decoded configuration at the top ports
module tcm_channel_config_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // bus handshakes and answers
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  // configuration outputs
  input wire logic [41:0] chanMode,
  input wire logic [5:0]  bufferPairAEn,
  input wire logic [5:0]  bufferPairBEn,
  input wire logic [5:0]  pwm2ClearLevelSel,
  input wire logic [5:0]  counterRunBit,
  input wire logic [5:0]  initOutApply,
  input wire logic [7:0]  ioSelC,
  input wire logic [7:0]  ioSelD,
  input wire logic [3:0]  eventEnCD
);
  // single domain, so clock and reset are given once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("late read");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read dropped");
  property p_wr_hold; s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("resp dropped");
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper)
    else $error("upper bits set");
  property p_no_buf; ((bufferPairAEn | bufferPairBEn) & 6'h36) == 6'h0;
  endproperty
  a_no_buf: assert property (p_no_buf)
    else $error("bad pair");
  property p_c_off; bufferPairAEn[0] |-> !eventEnCD[0] && ioSelC[3:0] == 4'h0;
  endproperty
  a_c_off: assert property (p_c_off)
    else $error("c live");
  property p_c3_off;
    bufferPairAEn[3] |-> !eventEnCD[2] && ioSelC[7:4] == 4'h0;
  endproperty
  a_c3_off: assert property (p_c3_off)
    else $error("c3 live");
  property p_d_off; bufferPairBEn[3] |-> !eventEnCD[3] && ioSelD[7:4] == 4'h0;
  endproperty
  a_d_off: assert property (p_d_off)
    else $error("d live");
  property p_d0_off;
    bufferPairBEn[0] |-> !eventEnCD[1] && ioSelD[3:0] == 4'h0;
  endproperty
  a_d0_off: assert property (p_d0_off)
    else $error("d0 live");
  property p_pwm2; pwm2ClearLevelSel[0] == (chanMode[6:0] == 7'h04);
  endproperty
  a_pwm2: assert property (p_pwm2)
    else $error("pwm2 flag");
  property p_onehot; $onehot(chanMode[13:7]); endproperty
  a_onehot: assert property (p_onehot)
    else $error("mode code");
  property p_init; initOutApply == ~counterRunBit; endproperty
  a_init: assert property (p_init)
    else $error("init apply");
endmodule

bind tcm_channel_config tcm_channel_config_checker u_chk (.*);

// ===== bench/test_tcm_channel_config.sv
`timescale 1ns/1ps

module test_tcm_channel_config;
  // bench drive
  logic        clk_sys = 1'b0, rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd;
  logic [3:0]  s_axi_wstrb = 4'hf, eventEnCD;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bready = 1'b0;
  // design answers
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [41:0] chanMode;
  logic [5:0]  bufferPairAEn, bufferPairBEn, pwm2ClearLevelSel;
  logic [5:0]  counterRunBit, initOutApply;
  logic [23:0] ioSelA, ioSelB;
  logic [7:0]  ioSelC, ioSelD, d;
  logic [7:0]  io [8];
  // expected answers, oldest first
  logic [1:0]  qb [$];
  logic [33:0] qr [$];
  int          n_fail = 0, checks_done = 0;
  integer      seed = 32'h5e1e3f14;

  tcm_channel_config DUT (.*);

  always #20 clk_sys = ~clk_sys;

  // one comparison, counted either way
  task automatic cmp(input logic [33:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // expected one-hot mode; reserved codes fall back to normal
  function automatic logic [6:0] mexp(input logic [3:0] c);
    if (c[3] || c[2:1] == 2'b00) return 7'h01;
    if (!c[2]) return c[0] ? 7'h04 : 7'h02;
    return 7'h08 << c[1:0];
  endfunction

  // one bus access; the answer is noted and judged by the monitor
  task automatic acc(input bit wr, input logic [11:0] a, input logic [7:0] w,
                     input logic [1:0] er, input logic [7:0] ed);
    logic [31:0] r;
    bit          ta, tw;
    int          n;
    r = $random(seed);
    ta = 1'b0;
    tw = !wr;
    n = 0;
    if (wr) qb.push_back(er);
    else qr.push_back({er, 24'h0, ed});
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {r[31:8], w};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    // hold each channel until its own ready is seen
    while (!(ta && tw) && n < 40) begin
      @(negedge clk_sys);
      ta |= wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      tw |= s_axi_wvalid && s_axi_wready;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (ta) s_axi_arvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    // a random stall before accepting the answer
    repeat (r[1:0]) @(posedge clk_sys);
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    ta = 1'b0;
    while (!ta && n < 80) begin
      @(negedge clk_sys);
      ta = wr ? s_axi_bvalid : s_axi_rvalid;
      @(posedge clk_sys);
      n++;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (n >= 80) cmp(34'h1, 34'h0, "no answer");
  endtask

  // answers are compared half a cycle before the edge that takes them,
  // where valid and ready are both settled
  always @(negedge clk_sys) begin
    if (s_axi_bvalid && s_axi_bready)
      cmp(34'(s_axi_bresp), 34'(qb.pop_front()), "resp");
    if (s_axi_rvalid && s_axi_rready)
      cmp({s_axi_rresp, s_axi_rdata}, qr.pop_front(), "read");
  end

  // cuts a hang short
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 6; i++) acc(0, 12'(4*i), 0, 2'b00, 8'hc0);
    for (int i = 0; i < 9; i++) acc(0, 12'(32+4*i), 0, 2'b00, 0);
    acc(0, 12'h044, 0, 2'b10, 8'h00);
    acc(1, 12'h100, 8'h55, 2'b10, 0);
    // every mode code software may write, junk in bits 7..4 of channel 1;
    // counters are all stopped while modes change
    for (int c = 0; c < 16; c++) begin
      rnd = $random(seed);
      d = {rnd[3:0], 1'b0, 3'(c)};
      acc(1, 12'h004, d, 2'b00, 0);
      acc(0, 12'h004, 0, 2'b00, {5'h18, 3'(c)});
      cmp(34'(chanMode[13:7]), 34'(mexp({1'b0, 3'(c)})), "mode");
    end
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      io[i] = rnd[7:0];
      acc(1, 12'(32+4*i), io[i], 2'b00, 0);
      acc(0, 12'(32+4*i), 0, 2'b00, io[i]);
    end
    for (int i = 0; i < 6; i++) begin
      cmp(34'(ioSelA[4*i+:4]), 34'(io[i][3:0]), "io a");
      cmp(34'(ioSelB[4*i+:4]), 34'(io[i][7:4]), "io b");
    end
    cmp(34'({ioSelD, ioSelC}), 34'({io[7][7:4], io[6][7:4],
        io[7][3:0], io[6][3:0]}), "io cd");
    // pairs on every channel; only 0 and 3 own c and d; bit 2 stays 0
    for (int i = 0; i < 6; i++) acc(1, 12'(4*i), 8'h33, 2'b00, 0);
    cmp(34'({bufferPairBEn, bufferPairAEn}), 34'h249,
        "pair");
    cmp(34'({eventEnCD, ioSelD, ioSelC}), 34'h0, "cd off");
    cmp(34'(pwm2ClearLevelSel), 34'h3f, "pwm2");
    cmp(34'(chanMode[20:0]), 34'({3{7'h04}}), "mode lo");
    cmp(34'(chanMode[41:21]), 34'({3{7'h04}}), "mode hi");
    acc(0, 12'h00c, 0, 2'b00, 8'hf3);
    // no strobe leaves the register alone
    s_axi_wstrb <= 4'h0;
    acc(1, 12'h000, 8'h00, 2'b00, 0);
    s_axi_wstrb <= 4'hf;
    acc(0, 12'h000, 0, 2'b00, 8'hf3);
    rnd = $random(seed);
    acc(1, 12'h040, {2'b00, rnd[5:0]}, 2'b00, 0);
    acc(0, 12'h040, 0, 2'b00, {2'b00, rnd[5:0]});
    cmp(34'({counterRunBit, initOutApply}),
        34'({rnd[5:0], ~rnd[5:0]}), "run");
    repeat (4) @(posedge clk_sys);
    results();
  end
endmodule

// ===== common/tcm_defs.svh
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH

// register byte offsets (six mode registers, eight io control registers)
`define TCM_MODE_BASE      12'h000
`define TCM_IOC_BASE       12'h020
`define TCM_RUN_OFFSET     12'h040
`define TCM_ADDR_TOP       5
`define TCM_NUM_CH         6
`define TCM_NUM_IOC        8

// mode register field positions
`define TCM_BUF_B_BIT      5
`define TCM_BUF_A_BIT      4
`define TCM_MODE_TOP_BIT   3

// reset and fixed values
`define TCM_MODE_RESET     8'hc0
`define TCM_RSVD_ONES      8'hc0
`define TCM_IOC_RESET      8'h00
`define TCM_RUN_RESET      6'h00

`endif

// ===== common/tcm_pkg.sv
package tcm_pkg;

  // decoded operating mode of one channel, one-hot
  typedef enum logic [6:0] {
    TCM_NORMAL = 7'h01,
    TCM_PWM1   = 7'h02,
    TCM_PWM2   = 7'h04,
    TCM_PHASE1 = 7'h08,
    TCM_PHASE2 = 7'h10,
    TCM_PHASE3 = 7'h20,
    TCM_PHASE4 = 7'h40
  } tcm_mode_t;

  // axi-lite slave state, one-hot
  typedef enum logic [2:0] {
    TCM_IDLE  = 3'h1,
    TCM_WRESP = 3'h2,
    TCM_RDATA = 3'h4
  } tcm_bus_state_t;

endpackage

// ===== verilog/tcm_channel_config.sv
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "tcm_defs.svh"

// How it works
// [RULE1] six 8-bit read/write channel mode registers
// [RULE2] software changes mode only while stopped
// [RULE3] mode bits 7,6 read one, ignore writes
// [RULE4] bit5 pairs register b with d
// [RULE5] buffer d raises no capture or compare
// [RULE6] bit5 reads zero on channels 1,2,4,5
// [RULE7] bit4 pairs register a with c
// [RULE8] buffer c raises no capture or compare
// [RULE9] bit4 reads zero on channels 1,2,4,5
// [RULE10] mode field decodes normal, pwm, phase
// [RULE11] software writes zero to mode top bit
// [RULE12] channels 0,3 get no phase counting; here they decode phase codes like the rest
// [RULE13] eight 8-bit read/write io control registers
// [RULE14] initial output applies while counter stopped
// [RULE15] pwm2 io sets level at counter clear
// [RULE16] buffer c/d io setting is ignored
// [RULE17] io bits 7..4 select register b function
// [RULE18] io bits 3..0 select register a function
// [RULE19] reserved mode codes act as normal
module tcm_channel_config (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // per-channel configuration to the timer core
  output logic [41:0]      chanMode,
  output logic [5:0]       bufferPairAEn,
  output logic [5:0]       bufferPairBEn,
  output logic [5:0]       pwm2ClearLevelSel,
  output logic [5:0]       counterRunBit,
  // general register a/b function per channel
  output logic [23:0]      ioSelA,
  output logic [23:0]      ioSelB,
  // general register c/d function on channels 0 and 3; initial output apply per channel
  output logic [7:0]       ioSelC,
  output logic [7:0]       ioSelD,
  output logic [3:0]       eventEnCD,
  output logic [5:0]       initOutApply
);

  // address map, one register in the low byte of each aligned word:
  //   0x000..0x014  mode registers, channel 0..5
  //   0x020..0x034  io control, channel 0..5 (high half on 0 and 3)
  //   0x038, 0x03c  io control low half of channels 0 and 3
  //   0x040         counter run bits, one per channel
  // anything else, or a misaligned address, answers slverr and is
  // dropped; bits 31..8 always read zero
  // channels with c and d registers
  localparam logic [5:0] HAS_CD = 6'b001001;

  // bits 7,6 are not stored; the read view supplies them as ones
  // storage: writable low six bits per mode register
  logic [5:0] modeBits [6];
  logic [7:0] ioCtrl   [8];     // 0..5 high/only, 6 = ch0 low, 7 = ch3 low
  logic [5:0] runBits;          // counter run bits, one per channel

  // bus state
  tcm_pkg::tcm_bus_state_t busState;
  logic        awHeld;          // write address captured
  logic        wHeld;           // write data captured
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;

  // read view of a mode register, reserved bits fixed
  function automatic logic [7:0] modeView(input int ch);
    logic [7:0] v;
    v = `TCM_RSVD_ONES | {2'h0, modeBits[ch]}; // [RULE3]
    if (!HAS_CD[ch]) begin
      v[`TCM_BUF_B_BIT] = 1'b0; // [RULE6]
      v[`TCM_BUF_A_BIT] = 1'b0; // [RULE9]
    end
    return v;
  endfunction

  // register index decode: returns 0..5 mode, 8..15 io, 16 run, 31 none
  function automatic logic [4:0] decodeAddr(input logic [11:0] a);
    logic [4:0] idx;
    // default: nothing mapped here
    idx = 5'h1f;
    // a misaligned address never decodes
    if (a[1:0] == 2'h0) begin
      if (a >= `TCM_MODE_BASE && a < `TCM_MODE_BASE + 12'h018) begin
        // one mode register per channel
        idx = 5'(a[11:2]);
      end else if (a >= `TCM_IOC_BASE && a < `TCM_IOC_BASE + 12'h020) begin
        // eight io control registers
        idx = 5'h08 + 5'(a[4:2]);
      end else if (a == `TCM_RUN_OFFSET) begin
        // shared counter run bits
        idx = 5'h10;
      end
    end
    return idx;
  endfunction

  logic        doWrite;
  logic [4:0]  wIdx;
  assign doWrite = awHeld & wHeld & (busState == tcm_pkg::TCM_IDLE);
  assign wIdx    = decodeAddr(awAddr);

  // handshake outputs; address/data taken independently
  // arready waits out a half-taken write so a read cannot slip past it
  assign s_axi_awready = ~awHeld & (busState == tcm_pkg::TCM_IDLE);
  assign s_axi_wready  = ~wHeld & (busState == tcm_pkg::TCM_IDLE);
  assign s_axi_arready = (busState == tcm_pkg::TCM_IDLE) & ~awHeld & ~wHeld;

  // capture write address and data in either order
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 12'h000;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else if (doWrite) begin
      // the write is carried out now, so both slots free up
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
    end else begin
      // each half is taken on its own handshake
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
    end
  end

  // bus sequencing; reads wait behind a half-taken write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busState     <= tcm_pkg::TCM_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      case (busState)
        tcm_pkg::TCM_IDLE: begin
          // a complete write goes first; arready is low meanwhile
          if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            // unmapped addresses answer slverr
            s_axi_bresp  <= (wIdx == 5'h1f) ? 2'h2 : 2'h0;
            busState     <= tcm_pkg::TCM_WRESP;
          end else if (s_axi_arvalid && s_axi_arready) begin
            // the answer is registered and stands until rready
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            // upper bits of every word read zero
            s_axi_rdata  <= 32'h0000_0000;
            case (decodeAddr(s_axi_araddr))
              // mode register with its fixed bits filled in
              5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: begin
                s_axi_rdata[7:0] <= modeView(int'(s_axi_araddr[4:2]));
              end
              // io control register, all bits stored
              5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f: begin
                s_axi_rdata[7:0] <= ioCtrl[s_axi_araddr[4:2]];
              end
              // counter run bits
              5'h10: s_axi_rdata[5:0] <= runBits;
              // unmapped: slverr, data stays zero
              default: s_axi_rresp <= 2'h2;
            endcase
            busState <= tcm_pkg::TCM_RDATA;
          end
        end
        tcm_pkg::TCM_WRESP: begin
          // the response stands until the master takes it
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            busState     <= tcm_pkg::TCM_IDLE;
          end
        end
        tcm_pkg::TCM_RDATA: begin
          // read data stands until the master takes it
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            busState     <= tcm_pkg::TCM_IDLE;
          end
        end
        // a corrupted state code falls back to idle
        default: busState <= tcm_pkg::TCM_IDLE;
      endcase
    end
  end

  // mode registers: only bits 5..0 store, byte lane 0 [RULE1]
  // a write with lane 0 unstrobed changes nothing, yet answers okay
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `TCM_NUM_CH; i++) begin
        modeBits[i] <= 6'(`TCM_MODE_RESET);
      end
    end else if (doWrite && wStrb[0] && wIdx < 5'h06) begin
      // bits 7,6 are never stored [RULE3]
      if (HAS_CD[wIdx[2:0]]) begin
        // channels 0 and 3 keep both buffer enables
        modeBits[wIdx[2:0]] <= wData[5:0];
      end else begin
        // no c or d here, so the pair bits stay zero
        modeBits[wIdx[2:0]] <= {2'h0, wData[3:0]}; // [RULE6] [RULE9]
      end
    end
  end

  // io control registers, reset to zero [RULE13]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `TCM_NUM_IOC; i++) begin
        ioCtrl[i] <= `TCM_IOC_RESET; // [RULE17] [RULE18]
      end
    end else if (doWrite && wStrb[0] && wIdx[4:3] == 2'h1) begin
      ioCtrl[wIdx[2:0]] <= wData[7:0];
    end
  end

  // counter run bits held here so initial-output gating can see them
  // limitation: only software starts or stops a channel in this block
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      runBits <= `TCM_RUN_RESET;
    end else if (doWrite && wStrb[0] && wIdx == 5'h10) begin
      runBits <= wData[5:0];
    end
  end
  assign counterRunBit = runBits;

  // per-channel decode and qualification
  for (genvar c = 0; c < `TCM_NUM_CH; c++) begin : g_ch
    tcm_pkg::tcm_mode_t m;
    logic               bA;
    logic               bB;
    // bits 7,6 go in as ones so the decoder sees the full byte
    tcm_mode_decode #(.HAS_CD(HAS_CD[c])) u_dec (
      .modeReg  ({2'h3, modeBits[c]}),
      .mode     (m),
      .bufPairA (bA),
      .bufPairB (bB)
    );
    assign chanMode[c*7 +: 7]   = m;
    assign bufferPairAEn[c]     = bA;
    assign bufferPairBEn[c]     = bB;
    // in pwm2 the io fields give the level at counter clear [RULE15]
    assign pwm2ClearLevelSel[c] = (m == tcm_pkg::TCM_PWM2);
    assign ioSelA[c*4 +: 4]     = ioCtrl[c][3:0]; // [RULE18]
    assign ioSelB[c*4 +: 4]     = ioCtrl[c][7:4]; // [RULE17]
    assign initOutApply[c]      = ~runBits[c];    // [RULE14]
  end

  // c and d qualification on channels 0 and 3 only
  for (genvar k = 0; k < 2; k++) begin : g_cd
    // slot 0 serves channel 0, slot 1 channel 3
    localparam int CH = k * 3;
    tcm_io_gate u_gate_c (
      .ioSel      (ioCtrl[6 + k][3:0]),
      .isBuffer   (bufferPairAEn[CH]),   // [RULE8]
      .counterRun (runBits[CH]),
      .ioEff      (ioSelC[k*4 +: 4]),
      .eventEn    (eventEnCD[k*2]),
      .initApply  ()
    );
    tcm_io_gate u_gate_d (
      .ioSel      (ioCtrl[6 + k][7:4]),
      .isBuffer   (bufferPairBEn[CH]),   // [RULE5]
      .counterRun (runBits[CH]),
      .ioEff      (ioSelD[k*4 +: 4]),
      .eventEn    (eventEnCD[k*2 + 1]),
      .initApply  ()
    );
  end

endmodule

// ===== verilog/tcm_io_gate.sv
`timescale 1ns/1ps

// qualifies one general register's io control field for the timer core
module tcm_io_gate (
  // configuration in
  input  wire logic [3:0] ioSel,
  input  wire logic       isBuffer,
  input  wire logic       counterRun,
  // qualified out
  output logic [3:0]      ioEff,
  output logic            eventEn,
  output logic            initApply
);

  // a buffer register ignores its io field and raises no events
  always_comb begin
    ioEff     = isBuffer ? 4'h0 : ioSel;      // [RULE16]
    eventEn   = ~isBuffer;                    // [RULE5] [RULE8]
    initApply = ~isBuffer & ~counterRun;      // [RULE14]
  end

endmodule

// ===== verilog/tcm_mode_decode.sv
`timescale 1ns/1ps
`include "tcm_defs.svh"

// decodes one channel's mode register into a one-hot mode and buffer flags
module tcm_mode_decode #(
  parameter bit HAS_CD = 1'b1  // channel owns registers c and d
) (
  // mode register contents
  input  wire logic [7:0]        modeReg,
  // decoded outputs
  output tcm_pkg::tcm_mode_t     mode,
  output logic                   bufPairA,
  output logic                   bufPairB
);

  // buffer flags only exist where c and d exist
  always_comb begin
    bufPairA = HAS_CD & modeReg[`TCM_BUF_A_BIT]; // [RULE7]
    bufPairB = HAS_CD & modeReg[`TCM_BUF_B_BIT]; // [RULE4]
  end

  // top bit set or reserved code falls back to normal [RULE19]
  always_comb begin
    if (modeReg[`TCM_MODE_TOP_BIT]) begin
      mode = tcm_pkg::TCM_NORMAL;
    end else begin
      case (modeReg[2:0]) // [RULE10]
        3'h2:    mode = tcm_pkg::TCM_PWM1;
        3'h3:    mode = tcm_pkg::TCM_PWM2;
        3'h4:    mode = tcm_pkg::TCM_PHASE1;
        3'h5:    mode = tcm_pkg::TCM_PHASE2;
        3'h6:    mode = tcm_pkg::TCM_PHASE3;
        3'h7:    mode = tcm_pkg::TCM_PHASE4;
        default: mode = tcm_pkg::TCM_NORMAL;
      endcase
    end
  end

endmodule
